/* rhp_pkg.sv */
// Purpose: Constants for the root hub port state register bits, low and high half
// Assumes: One port, register reached by a simple word access port
// Notes: Change flags sit at their customary high-half positions
`default_nettype none
package rhp_pkg;
  localparam logic [7:0] ROOT_HUB_PORT_STATE_OFFSET = 8'h54;
  localparam int BIT_CONNECT = 0;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_SUSPEND = 2;
  localparam int BIT_RESUME = 3;
  localparam int BIT_RESET = 4;
  localparam int BIT_CONNECT_CHG = 16;
  localparam int BIT_ENABLE_CHG = 17;
  localparam int BIT_SUSPEND_CHG = 18;
  localparam int BIT_RESET_CHG = 20;
  localparam logic RESET_VALUE_FLAG = 1'b0;
  // Resume and reset signalling durations in cycles at 100 MHz
  localparam int RESUME_TIME_US = 20000;
  localparam int RESET_TIME_US = 10000;
  localparam int CLOCK_MHZ = 100;
  localparam int RESUME_CYCLES = RESUME_TIME_US * CLOCK_MHZ;
  localparam int RESET_CYCLES = RESET_TIME_US * CLOCK_MHZ;
endpackage
`default_nettype wire

/* rhp_port_status.sv */
// Purpose: Root hub port suspend, enable and connection status bits
// Assumes: Connect, fault and upstream resume inputs come from pins
// Notes: Change flags are cleared by writing 1 to them
// Functional notes
// R01 - A write of 1 to bit 2 on a connected, enabled port sets the suspended flag, read as bit 2.
// R02 - The suspended flag clears at the end of resume as the suspend change flag sets.
// R03 - A suspend write on a disconnected port sets the connect change flag instead.
// R04 - Reset completion or global resume also clears the suspended flag.
// R05 - An upstream resume from a suspended port is passed to the host controller.
// R06 - Bit 1 shows enable and the hub clears it on faults or disconnect.
// R07 - A hub-side disable sets the enable change flag.
// R08 - A write of 1 to bit 1 on a connected port sets enable.
// R09 - An enable write on a disconnected port sets the connect change flag instead.
// R10 - Reset or suspend completion sets the enable flag.
// R11 - Bit 0 shows the live connection.
// R12 - A write of 1 to bit 0 clears enable.
// R13 - No write changes the connection bit.
// R14 - A non-removable device makes bit 0 read 1.
// R15 - A write of 1 to bit 4 on a connected port starts reset until its completion.
// R16 - A write of 1 to bit 3 starts resume only while suspended.
// R17 - Change flags are sticky bits in the same register.
`default_nettype none
module rhp_port_status #(
  parameter int RESUME_COUNT = rhp_pkg::RESUME_CYCLES,
  parameter int RESET_COUNT = rhp_pkg::RESET_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic device_attach_pin,
  input wire logic overcurrent_pin,
  input wire logic upstream_resume_pin,
  input wire logic power_off,
  input wire logic bus_error,
  input wire logic global_resume_state,
  input wire logic removable_device_bitmap,
  output logic port_reset_signal,
  output logic port_resume_signal,
  output logic resume_to_controller
);
  logic attach_s1_reg;
  logic attach_reg;
  logic oc_s1_reg;
  logic oc_reg;
  logic rsm_s1_reg;
  logic rsm_reg;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      attach_s1_reg <= 1'b0;
      attach_reg <= 1'b0;
      oc_s1_reg <= 1'b0;
      oc_reg <= 1'b0;
      rsm_s1_reg <= 1'b0;
      rsm_reg <= 1'b0;
    end
    else
    begin
      attach_s1_reg <= device_attach_pin;
      attach_reg <= attach_s1_reg;
      oc_s1_reg <= overcurrent_pin;
      oc_reg <= oc_s1_reg;
      rsm_s1_reg <= upstream_resume_pin;
      rsm_reg <= rsm_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only the one mapped word answers; every other address reads 0
  function automatic logic is_port_word(input logic [7:0] addr);
    return addr == rhp_pkg::ROOT_HUB_PORT_STATE_OFFSET;
  endfunction

  // Written bits act only when set; a 0 leaves its target alone
  function automatic logic cmd_bit(input logic [31:0] data, input int pos);
    return data[pos];
  endfunction

  logic hit;
  logic connected;
  logic attach_prev_reg;
  logic wr_connect;
  logic wr_enable;
  logic wr_suspend;
  logic wr_resume;
  logic wr_reset;
  logic port_enabled_flag;
  logic port_suspended_flag;
  logic port_reset_flag;
  logic resuming_reg;
  logic connect_change_flag;
  logic enable_change_flag;
  logic suspend_change_flag;
  logic reset_change_flag;
  logic [31:0] resume_count_reg;
  logic [31:0] reset_count_reg;
  logic start_resume;
  logic start_reset;
  logic resume_done;
  logic reset_done;
  logic hub_disable;
  assign hit = reg_write && is_port_word(reg_addr);
  assign connected = attach_reg || !removable_device_bitmap; // [R11] [R14]
  assign wr_connect = hit && cmd_bit(reg_wdata, rhp_pkg::BIT_CONNECT);
  assign wr_enable = hit && cmd_bit(reg_wdata, rhp_pkg::BIT_ENABLE);
  assign wr_suspend = hit && cmd_bit(reg_wdata, rhp_pkg::BIT_SUSPEND);
  assign wr_resume = hit && cmd_bit(reg_wdata, rhp_pkg::BIT_RESUME);
  assign wr_reset = hit && cmd_bit(reg_wdata, rhp_pkg::BIT_RESET);
  assign start_reset = wr_reset && connected && !port_reset_flag; // [R15]
  assign start_resume = wr_resume && port_suspended_flag && !resuming_reg && !port_reset_flag;
  assign resume_done = resuming_reg && (resume_count_reg == 32'h0);
  assign reset_done = port_reset_flag && (reset_count_reg == 32'h0);
  assign hub_disable = port_enabled_flag &&
    (oc_reg || !connected || power_off || bus_error); // [R06]

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      attach_prev_reg <= 1'b0;
    else
      attach_prev_reg <= connected;
  end

  // One counter per interval, so starting one never reloads the other
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      reset_count_reg <= 32'h0;
    end
    else if (start_reset)
    begin
      reset_count_reg <= 32'(RESET_COUNT - 1);
    end
    else if (port_reset_flag && reset_count_reg != 32'h0)
    begin
      reset_count_reg <= reset_count_reg - 32'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      resume_count_reg <= 32'h0;
    end
    else if (start_resume)
    begin
      resume_count_reg <= 32'(RESUME_COUNT - 1);
    end
    else if (resuming_reg && resume_count_reg != 32'h0)
    begin
      resume_count_reg <= resume_count_reg - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      port_reset_flag <= rhp_pkg::RESET_VALUE_FLAG;
    else if (reset_done)
      port_reset_flag <= 1'b0; // [R15]
    else if (wr_reset && connected)
      port_reset_flag <= 1'b1; // [R15]
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      resuming_reg <= 1'b0;
    else if (resume_done || reset_done || global_resume_state || !connected)
      resuming_reg <= 1'b0;
    else if (start_resume)
      resuming_reg <= 1'b1; // [R16]
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      port_suspended_flag <= rhp_pkg::RESET_VALUE_FLAG;
    else if (resume_done)
      port_suspended_flag <= 1'b0; // [R02]
    else if (reset_done || global_resume_state || !connected)
      port_suspended_flag <= 1'b0; // [R04]
    else if (wr_suspend && connected && port_enabled_flag)
      port_suspended_flag <= 1'b1; // [R01]
  end

  // Disable commands, and faults on an already enabled port, win over enabling in the same cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      port_enabled_flag <= rhp_pkg::RESET_VALUE_FLAG;
    else if (hub_disable)
      port_enabled_flag <= 1'b0; // [R06]
    else if (wr_connect)
      port_enabled_flag <= 1'b0; // [R12]
    else if (reset_done || resume_done)
      port_enabled_flag <= 1'b1; // [R10]
    else if (wr_enable && connected)
      port_enabled_flag <= 1'b1; // [R08]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky change flags: hardware set wins over a write-1 clear
  logic clr_connect_chg;
  logic clr_enable_chg;
  logic clr_suspend_chg;
  logic clr_reset_chg;
  logic set_connect_chg;
  assign clr_connect_chg = hit && cmd_bit(reg_wdata, rhp_pkg::BIT_CONNECT_CHG);
  assign clr_enable_chg = hit && cmd_bit(reg_wdata, rhp_pkg::BIT_ENABLE_CHG);
  assign clr_suspend_chg = hit && cmd_bit(reg_wdata, rhp_pkg::BIT_SUSPEND_CHG);
  assign clr_reset_chg = hit && cmd_bit(reg_wdata, rhp_pkg::BIT_RESET_CHG);
  assign set_connect_chg = (connected != attach_prev_reg) ||
    (!connected && (wr_suspend || wr_enable || wr_reset)); // [R03] [R09]

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      connect_change_flag <= 1'b0;
    end
    else
    begin
      connect_change_flag <= set_connect_chg ||
        (connect_change_flag && !clr_connect_chg); // [R17]
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      enable_change_flag <= 1'b0;
    end
    else
    begin
      enable_change_flag <= hub_disable ||
        (enable_change_flag && !clr_enable_chg); // [R07]
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      suspend_change_flag <= 1'b0;
    end
    else
    begin
      suspend_change_flag <= resume_done ||
        (suspend_change_flag && !clr_suspend_chg); // [R02]
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      reset_change_flag <= 1'b0;
    end
    else
    begin
      reset_change_flag <= reset_done ||
        (reset_change_flag && !clr_reset_chg); // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      resume_to_controller <= 1'b0;
    else
      resume_to_controller <= rsm_reg && port_suspended_flag; // [R05]
  end

  assign port_reset_signal = port_reset_flag;
  assign port_resume_signal = resuming_reg;

  // Writes never reach the connection bit; it is rebuilt from the pin
  logic [31:0] rdata_next;
  always_comb
  begin
    rdata_next = 32'h0;
    rdata_next[rhp_pkg::BIT_CONNECT] = connected; // [R11] [R13]
    rdata_next[rhp_pkg::BIT_ENABLE] = port_enabled_flag; // [R06]
    rdata_next[rhp_pkg::BIT_SUSPEND] = port_suspended_flag; // [R01]
    rdata_next[rhp_pkg::BIT_RESET] = port_reset_flag; // [R15]
    rdata_next[rhp_pkg::BIT_CONNECT_CHG] = connect_change_flag; // [R17]
    rdata_next[rhp_pkg::BIT_ENABLE_CHG] = enable_change_flag;
    rdata_next[rhp_pkg::BIT_SUSPEND_CHG] = suspend_change_flag;
    rdata_next[rhp_pkg::BIT_RESET_CHG] = reset_change_flag;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= 32'h0;
    end
    else if (reg_read && is_port_word(reg_addr))
    begin
      reg_rdata <= rdata_next;
    end
    else
    begin
      reg_rdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

/* rhp_port_sva.sv */
// Purpose: Checker for the port status bits
// Assumes: Word access port at 0x54
// Notes: Counts follow the design parameters
`default_nettype none
module rhp_port_sva #(
  parameter int RESUME_COUNT = 8,
  parameter int RESET_COUNT = 5
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic upstream_resume_pin,
  input wire logic port_reset_signal,
  input wire logic port_resume_signal,
  input wire logic resume_to_controller
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hit;
  int rs_cnt;
  int rm_cnt;
  assign hit = reg_write && reg_addr == 8'h54;
  always_ff @(posedge clock or negedge resetn)
    if (!resetn) rs_cnt <= 0;
    else rs_cnt <= port_reset_signal ? rs_cnt + 1 : 0;
  always_ff @(posedge clock or negedge resetn)
    if (!resetn) rm_cnt <= 0;
    else rm_cnt <= port_resume_signal ? rm_cnt + 1 : 0;
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_idle_rdata: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("rdata not zero when idle");
  a_spare_bits: assert property (reg_read |=> (reg_rdata & 32'hffe8ffe8) == 32'h0)
    else $error("unmapped bit reads one");
  a_reset_read: assert property (reg_read && reg_addr == 8'h54
    |=> reg_rdata[4] == $past(port_reset_signal)) else $error("reset bit mismatch");
  a_reset_start: assert property ($rose(port_reset_signal) |-> $past(hit && reg_wdata[4]))
    else $error("reset began without a write");
  a_resume_start: assert property ($rose(port_resume_signal) |-> $past(hit && reg_wdata[3]))
    else $error("resume began without a write");
  a_reset_length: assert property ($fell(port_reset_signal) |-> rs_cnt >= RESET_COUNT - 1)
    else $error("reset too short");
  a_reset_bound: assert property (rs_cnt <= RESET_COUNT + 2)
    else $error("reset too long");
  a_resume_length: assert property ($fell(port_resume_signal) |->
    rm_cnt >= RESUME_COUNT - 1 && rm_cnt <= RESUME_COUNT + 2) else $error("resume length");
  a_wake_source: assert property (!upstream_resume_pin [*4] |=> !resume_to_controller)
    else $error("resume passed up without cause");
  c_reset_done: cover property ($fell(port_reset_signal));
  c_resume_done: cover property ($fell(port_resume_signal));
  c_wake_up: cover property (resume_to_controller);
endmodule
bind rhp_port_status rhp_port_sva #(.RESUME_COUNT(RESUME_COUNT), .RESET_COUNT(RESET_COUNT))
  chk_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .upstream_resume_pin(upstream_resume_pin), .port_reset_signal(port_reset_signal),
  .port_resume_signal(port_resume_signal), .resume_to_controller(resume_to_controller));
`default_nettype wire

/* rhp_dev_model.sv */
// Purpose: Downstream device on the port
// Assumes: Bench asks for plug and wake
// Notes: Wake only while plugged in
`default_nettype none
module rhp_dev_model (
  input wire logic clock,
  input wire logic plug,
  input wire logic wake,
  output logic device_attach_pin,
  output logic upstream_resume_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clock)
  begin
    device_attach_pin <= plug;
    upstream_resume_pin <= wake && plug;
  end
endmodule
`default_nettype wire

/* rhp_port_status_bench.sv */
// Purpose: Self-checking bench for the port status bits
// Assumes: Short resume and reset counts
// Notes: Reads are checked through an expectation queue
`default_nettype none
module rhp_port_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, resetn = 0, reg_write = 0, reg_read = 0, rd_d = 0;
  logic oc = 0, pwr = 0, berr = 0, gres = 0, remov = 1, plug = 0, wake = 0;
  logic attach, wpin, rsig, msig, upc;
  logic [7:0] reg_addr = 8'h54;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [63:0] exp_q[$];
  logic [63:0] ent;
  int err_total = 0, cmp_count = 0, cyc = 0;
  always #5 clock = ~clock;
  rhp_port_status #(.RESUME_COUNT(8), .RESET_COUNT(5)) dut_u (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .device_attach_pin(attach), .overcurrent_pin(oc),
    .upstream_resume_pin(wpin), .power_off(pwr), .bus_error(berr), .global_resume_state(gres),
    .removable_device_bitmap(remov), .port_reset_signal(rsig), .port_resume_signal(msig),
    .resume_to_controller(upc));
  rhp_dev_model dev_u (.clock(clock), .plug(plug), .wake(wake), .device_attach_pin(attach),
    .upstream_resume_pin(wpin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(posedge clock);
    reg_addr <= 8'h54;
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge clock);
    reg_write <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1;
    exp_q.push_back({e, m});
    @(posedge clock);
    reg_read <= 0;
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock)
  begin
    rd_d <= reg_read;
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_total++;
      finish_test();
    end
  end
  always @(negedge clock)
    if (rd_d)
    begin
      ent = exp_q.pop_front();
      chk(reg_rdata & ent[31:0], ent[63:32]);
    end
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(43665));
    repeat (10) @(posedge clock);
    resetn <= 1;
    rd(8'h54, 32'h0, 32'h17_0017);
    wr(32'h16);
    rd(8'h54, 32'h1_0000, 32'h17_0017);
    wr(32'h1_0000);
    plug <= 1;
    repeat (5) @(posedge clock);
    rd(8'h54, 32'h1_0001, 32'h1_0017);
    wr(32'h1_0000);
    wr(32'h0);
    rd(8'h54, 32'h1, 32'h17_0017);
    wr(32'h2);
    wr(32'h1);
    rd(8'h54, 32'h1, 32'h7);
    wr(32'h2);
    wr(32'h4);
    rd(8'h54, 32'h7, 32'h7);
    wr(32'h1);
    wr(32'h8);
    @(negedge clock);
    chk({31'h0, msig}, 32'h1);
    repeat (12) @(posedge clock);
    rd(8'h54, 32'h4_0003, 32'h4_0007);
    wr(32'h4);
    gres <= 1;
    @(posedge clock);
    gres <= 0;
    rd(8'h54, 32'h0, 32'h4);
    wr(32'h8);
    @(negedge clock);
    chk({31'h0, msig}, 32'h0);
    wr(32'h2);
    wr(32'h4);
    wake <= 1;
    repeat (5) @(posedge clock);
    wake <= 0;
    @(negedge clock);
    chk({31'h0, upc}, 32'h1);
    wr(32'h10);
    @(negedge clock);
    chk({31'h0, rsig}, 32'h1);
    rd(8'h54, 32'h10, 32'h10);
    repeat (10) @(posedge clock);
    rd(8'h54, 32'h10_0003, 32'h10_0017);
    for (int i = 0; i < 3; i++)
    begin
      wr(32'h17_0002);
      {berr, pwr, oc} <= 3'b1 << i;
      repeat (4) @(posedge clock);
      {berr, pwr, oc} <= 3'b0;
      rd(8'h54, 32'h2_0001, 32'h2_0003);
    end
    wr(32'h2);
    wr(32'h17_0000);
    plug <= 0;
    repeat (5) @(posedge clock);
    rd(8'h54, 32'h3_0000, 32'h3_0003);
    remov <= 0;
    repeat (3) rd(8'($urandom_range(8'h53)), 32'h0, 32'hffff_ffff);
    rd(8'h54, 32'h1, 32'h1);
    repeat (3) @(posedge clock);
    finish_test();
  end
endmodule
`default_nettype wire
